// ==== src/i2cms_top.sv ====
// master command sequencer of a two-wire serial controller
// assumes an apb master on core_clk_i and open-drain pads resolved outside
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module i2cms_top (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             raw_int_o,
  output logic             irq_o
);
  import i2cms_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]  slv_addr_q;
  logic [7:0]  data_q;
  logic [7:0]  tpr_q;
  logic        imask_q;
  logic        raw_q;
  logic        irq_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        scl_meta_q;
  logic        scl_sync_q;
  logic        sda_meta_q;
  logic        sda_sync_q;
  logic        sda_prev_q;
  logic        busbsy_q;
  i2cms_eng_t  eng_q;
  i2cms_mode_t mode_q;
  i2cms_op_t   op_q;
  logic        held_q;
  logic [7:0]  shift_q;
  logic [2:0]  cnt_q;
  logic        samp_q;
  logic        adrack_q;
  logic        datack_q;
  logic        arblst_q;
  logic [8:0]  pre_q;
  logic [3:0]  ph_q;
  logic        scl_oe_q;
  logic        sda_oe_q;
  logic        scl_oe_d;
  logic        sda_oe_d;
  logic        pin_lvl_q;

  // ----------------------------------------------------------------
  // command decode for the idle, transmit and receive states
  // ----------------------------------------------------------------
  function automatic i2cms_op_t decode(input i2cms_mode_t m,
                                       input logic        dir,
                                       input logic [3:0]  c);
    i2cms_op_t o;
    logic      a;
    logic      p;
    logic      s;
    logic      r;
    a = c[CMD_ACK];
    p = c[CMD_STOP];
    s = c[CMD_START];
    r = c[CMD_RUN];
    o = '0;
    o.next = m;
    // start rows are alike in every state; read+ack+stop is excluded
    if (s && r && !(dir && a && p)) begin
      o.valid = 1'b1;
      o.start = 1'b1;
      o.xfer  = 1'b1;
      o.rx    = dir;
      o.stop  = p;
      o.ack   = dir & a;
      o.next  = p ? M_IDLE : (dir ? M_RX : M_TX);
    end else if (m != M_IDLE && !s && p && !r) begin
      o.valid = 1'b1;
      o.stop  = 1'b1;
      o.next  = M_IDLE;
    end else if (m == M_TX && !s && r) begin
      o.valid = 1'b1;
      o.xfer  = 1'b1;
      o.stop  = p;
      o.next  = p ? M_IDLE : M_TX;
    end else if (m == M_RX && !s && r && !(a && p)) begin
      o.valid = 1'b1;
      o.xfer  = 1'b1;
      o.rx    = 1'b1;
      o.ack   = a;
      o.stop  = p;
      o.next  = p ? M_IDLE : M_RX;
    end
    return o; // anything else stays a no-op
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ----------------------------------------------------------------
  // apb decode and command launch
  // ----------------------------------------------------------------
  wire         setup    = psel_i & ~penable_i;
  wire         acc      = psel_i & penable_i & pready_q;
  wire         wr       = acc & pwrite_i;
  wire         busy     = eng_q != E_IDLE;
  wire         hit_sa   = hit(paddr_i, OFF_SLV_ADDR);
  wire         hit_cmd  = hit(paddr_i, OFF_CMD_STAT);
  wire         hit_dat  = hit(paddr_i, OFF_DATA);
  wire         hit_tpr  = hit(paddr_i, OFF_PERIOD);
  wire         hit_im   = hit(paddr_i, OFF_IMASK);
  wire         hit_raw  = hit(paddr_i, OFF_RAW_INT);
  wire         hit_clr  = hit(paddr_i, OFF_INT_CLR);
  wire         mapped   = hit_sa | hit_cmd | hit_dat | hit_tpr | hit_im |
                          hit_raw | hit_clr;
  wire         cmd_wr   = wr & hit_cmd;
  wire i2cms_op_t dec   = decode(mode_q, slv_addr_q[SA_DIR], pwdata_i[3:0]);
  wire         launch   = cmd_wr & ~busy & dec.valid;

  // status view; stale result bits are hidden while busy
  i2cms_stat_t stat;
  assign stat.busy   = busy;
  assign stat.error  = ~busy & (adrack_q | datack_q | arblst_q);
  assign stat.adrack = ~busy & adrack_q;
  assign stat.datack = ~busy & datack_q;
  assign stat.arblst = ~busy & arblst_q;
  assign stat.idle   = ~busy & (mode_q == M_IDLE);
  assign stat.busbsy = ~busy & busbsy_q;

  // read mux; upper bits read as zero, never as stale data
  wire [7:0]  rd_byte = hit_sa  ? slv_addr_q :
                        hit_cmd ? {1'b0, stat} :
                        hit_dat ? data_q :
                        hit_tpr ? tpr_q :
                        hit_im  ? {7'h00, imask_q} :
                        hit_raw ? {7'h00, raw_q} : 8'h00;
  wire [31:0] rd_word = {24'h000000, rd_byte};

  // ----------------------------------------------------------------
  // apb answer: registered in setup, so every access has no wait state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q  <= (setup & ~pwrite_i) ? rd_word : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // software registers; only the low byte of a write is used
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      slv_addr_q <= SLV_RST;
      tpr_q      <= PERIOD_RST;
      imask_q    <= 1'b0;
    end else begin
      if (wr && hit_sa && !busy) slv_addr_q <= pwdata_i[7:0];
      if (wr && hit_tpr && !busy) tpr_q <= pwdata_i[7:0];
      if (wr && hit_im) imask_q <= pwdata_i[INT_BIT];
    end
  end

  // data byte: loaded by software, overwritten by a received byte
  wire rx_done;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      data_q <= DATA_RST;
    end else if (rx_done) begin
      data_q <= {shift_q[6:0], samp_q};
    end else if (wr && hit_dat && !busy) begin
      data_q <= pwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // raw interrupt and mask; a completion beats a same-cycle clear
  // ----------------------------------------------------------------
  wire done_evt;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      raw_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (done_evt) raw_q <= 1'b1;
      else if (wr && hit_clr && pwdata_i[INT_BIT]) raw_q <= 1'b0;
      irq_q <= raw_q & imask_q;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and bus busy detection
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_meta_q <= scl_i;
      scl_sync_q <= scl_meta_q;
      sda_meta_q <= sda_i;
      sda_sync_q <= sda_meta_q;
      sda_prev_q <= sda_sync_q;
    end
  end

  wire start_det = scl_sync_q & sda_prev_q & ~sda_sync_q;
  wire stop_det  = scl_sync_q & ~sda_prev_q & sda_sync_q;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) busbsy_q <= 1'b0;
    else if (start_det) busbsy_q <= 1'b1;
    else if (stop_det) busbsy_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // serial clock timebase: ticks every 2*(1+period) clocks, 10 per slot
  // ----------------------------------------------------------------
  wire [8:0] pre_lim  = {tpr_q, 1'b1};
  wire       tick     = busy & (pre_q == pre_lim);
  wire       tick_end = tick & (ph_q == PH_LAST);
  wire       tick_smp = tick & (ph_q == PH_SAMPLE);
  assign rx_done = tick_end & (eng_q == E_DATA) & op_q.rx & (cnt_q == 3'h0);
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !busy || tick) pre_q <= 9'h000;
    else pre_q <= pre_q + 9'h001;
  end

  // six ticks low then four high per bit slot
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !busy) ph_q <= 4'h0;
    else if (tick) ph_q <= (ph_q == PH_LAST) ? 4'h0 : ph_q + 4'h1;
  end

  // sampled line level, taken in the middle of the high phase
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) samp_q <= 1'b1;
    else if (tick_smp) samp_q <= sda_sync_q;
  end

  // ----------------------------------------------------------------
  // bit engine: start, address, ack, data, ack, stop slots
  // ----------------------------------------------------------------
  wire drives_data = (eng_q == E_START) | (eng_q == E_ADDR) |
                     ((eng_q == E_DATA) & ~op_q.rx);
  // a released line that reads low means another master won
  wire arb_lost = tick_smp & drives_data & ~sda_oe_q & ~sda_sync_q;
  wire nack     = samp_q;
  assign done_evt = arb_lost | (tick_end & (
                    (eng_q == E_STOP) |
                    ((eng_q == E_DACK) & ~op_q.stop) |
                    ((eng_q == E_AACK) & nack & ~op_q.stop)));
  wire [7:0] load_byte = op_q.rx ? 8'hFF : data_q;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      eng_q    <= E_IDLE;
      mode_q   <= M_IDLE;
      op_q     <= '0;
      held_q   <= 1'b0;
      shift_q  <= 8'h00;
      cnt_q    <= 3'h0;
      adrack_q <= 1'b0;
      datack_q <= 1'b0;
      arblst_q <= 1'b0;
    end else if (launch) begin
      op_q     <= dec;
      mode_q   <= dec.next;
      eng_q    <= dec.start ? E_START : (dec.xfer ? E_DATA : E_STOP);
      shift_q  <= dec.rx ? 8'hFF : data_q;
      cnt_q    <= 3'h7;
      adrack_q <= 1'b0;
      datack_q <= 1'b0;
      arblst_q <= 1'b0;
    end else if (arb_lost) begin
      eng_q    <= E_IDLE;
      mode_q   <= M_IDLE;
      held_q   <= 1'b0;
      arblst_q <= 1'b1;
    end else if (tick_end) begin
      case (eng_q)
        E_START: begin
          eng_q   <= E_ADDR;
          shift_q <= slv_addr_q;
          cnt_q   <= 3'h7;
          held_q  <= 1'b1;
        end
        E_ADDR, E_DATA: begin
          shift_q <= {shift_q[6:0], samp_q};
          cnt_q   <= cnt_q - 3'h1;
          if (cnt_q == 3'h0) eng_q <= (eng_q == E_ADDR) ? E_AACK : E_DACK;
        end
        E_AACK: begin
          adrack_q <= nack;
          shift_q  <= load_byte;
          cnt_q    <= 3'h7;
          // an unanswered address skips the data byte
          if (nack) eng_q <= op_q.stop ? E_STOP : E_IDLE;
          else eng_q <= E_DATA;
        end
        E_DACK: begin
          datack_q <= ~op_q.rx & nack;
          eng_q    <= op_q.stop ? E_STOP : E_IDLE;
        end
        E_STOP: begin
          eng_q  <= E_IDLE;
          held_q <= 1'b0;
        end
        default: eng_q <= E_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive; data changes two ticks into the low phase for hold time
  // ----------------------------------------------------------------
  wire low_ph  = ph_q < PH_HIGH;
  wire drv_win = ph_q >= PH_DRIVE;
  wire sda_edg = ph_q >= PH_SDA_EDGE;
  always_comb begin
    scl_oe_d = low_ph;
    sda_oe_d = sda_oe_q;
    case (eng_q)
      E_IDLE: begin
        scl_oe_d = held_q; // keep the bus stretched between commands
        sda_oe_d = held_q & sda_oe_q;
      end
      E_START: begin
        // from a free bus the clock is never pulled before the start
        scl_oe_d = held_q & low_ph;
        if (sda_edg) sda_oe_d = 1'b1;
        else if (drv_win) sda_oe_d = 1'b0;
      end
      E_ADDR: if (drv_win) sda_oe_d = ~shift_q[7];
      E_DATA: if (drv_win) sda_oe_d = ~op_q.rx & ~shift_q[7];
      E_AACK: if (drv_win) sda_oe_d = 1'b0;
      E_DACK: if (drv_win) sda_oe_d = op_q.rx & op_q.ack;
      E_STOP: begin
        if (sda_edg) sda_oe_d = 1'b0;
        else if (drv_win) sda_oe_d = 1'b1;
      end
      default: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      scl_oe_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
      pin_lvl_q <= 1'b0;
    end else begin
      scl_oe_q  <= scl_oe_d;
      sda_oe_q  <= sda_oe_d;
      pin_lvl_q <= 1'b0; // open drain: only ever pulls low
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;
  assign scl_o     = pin_lvl_q;
  assign sda_o     = pin_lvl_q;
  assign scl_oe_o  = scl_oe_q;
  assign sda_oe_o  = sda_oe_q;
  assign raw_int_o = raw_q;
  assign irq_o     = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  logic [12:0] slot_cyc_q;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !busy || tick_end) slot_cyc_q <= 13'h0000;
    else slot_cyc_q <= slot_cyc_q + 13'h0001;
  end
  wire [12:0] slot_len = 13'(SLOT_PHASES * 2) * (13'(tpr_q) + 13'h0001);

  sequence stop_only_s;
    launch && dec.stop && !dec.xfer;
  endsequence
  sequence tx_go_s;
    launch && mode_q == M_TX && !dec.start && dec.xfer;
  endsequence

  stop_only_a: assert property (stop_only_s |=>
    eng_q == E_STOP && mode_q == M_IDLE ##1 eng_q == E_STOP)
    else $error("stop-only command did not issue a stop");
  tx_stay_a: assert property (tx_go_s and !dec.stop |=>
    eng_q == E_DATA && mode_q == M_TX && !op_q.rx)
    else $error("send command left transmit state");
  tx_stop_a: assert property (tx_go_s and dec.stop |=>
    eng_q == E_DATA && mode_q == M_IDLE && op_q.stop)
    else $error("send with stop did not head for idle");
  rep_start_a: assert property (launch && dec.start |=>
    eng_q == E_START && mode_q == $past(dec.next))
    else $error("start command did not restart");
  rx_enter_a: assert property (launch && dec.start && dec.rx &&
    !dec.stop |=> mode_q == M_RX && op_q.rx)
    else $error("read restart did not enter receive");
  nop_cmd_a: assert property (cmd_wr && !busy && !dec.valid |=>
    eng_q == E_IDLE && $stable(mode_q))
    else $error("illegal command changed the state");
  reg_reset_a: assert property (disable iff (1'b0) !rstn_i |=>
    data_q == DATA_RST && tpr_q == PERIOD_RST && !imask_q)
    else $error("register reset values wrong");
  slot_len_a: assert property (tick_end |->
    slot_cyc_q == slot_len - 13'h0001)
    else $error("bit slot length wrong");
  ack_drive_a: assert property (eng_q == E_DACK && op_q.rx &&
    ph_q >= PH_SAMPLE |-> sda_oe_q == op_q.ack)
    else $error("receive acknowledge level wrong");
  irq_gate_a: assert property (1'b1 |=>
    irq_o == $past(raw_q && imask_q))
    else $error("interrupt output not gated by mask");
  done_int_a: assert property (done_evt |=> raw_q [*2])
    else $error("completion did not raise the raw interrupt");
  busy_stat_a: assert property (setup && hit_cmd && busy &&
    !pwrite_i |=> prdata_o[7:0] == 8'h01)
    else $error("status bits visible while busy");
  upper_zero_a: assert property (pready_o |->
    prdata_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");

endmodule

// ==== src/i2cms_pkg.sv ====
// shared constants and types of the two-wire master command sequencer
// assumes a 32-bit apb slave port with byte addresses in paddr[7:0]
package i2cms_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SLV_ADDR = 8'h00;
  localparam logic [7:0] OFF_CMD_STAT = 8'h04;
  localparam logic [7:0] OFF_DATA     = 8'h08;
  localparam logic [7:0] OFF_PERIOD   = 8'h0C;
  localparam logic [7:0] OFF_IMASK    = 8'h10;
  localparam logic [7:0] OFF_RAW_INT  = 8'h14;
  localparam logic [7:0] OFF_INT_CLR  = 8'h1C;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'h01;
  localparam logic [7:0] SLV_RST    = 8'h00;
  localparam int CMD_RUN   = 0;
  localparam int CMD_START = 1;
  localparam int CMD_STOP  = 2;
  localparam int CMD_ACK   = 3;
  localparam int SA_DIR    = 0;
  localparam int INT_BIT   = 0;

  // ----------------------------------------------------------------
  // serial clock timing, in prescaler ticks of 2*(1+period) clocks
  // ----------------------------------------------------------------
  localparam int LOW_PHASE_CNT  = 6;
  localparam int HIGH_PHASE_CNT = 4;
  localparam int SLOT_PHASES    = LOW_PHASE_CNT + HIGH_PHASE_CNT;
  localparam logic [3:0] PH_LAST     = 4'(SLOT_PHASES - 1);
  localparam logic [3:0] PH_HIGH     = 4'(LOW_PHASE_CNT);
  localparam logic [3:0] PH_DRIVE    = 4'h2;
  localparam logic [3:0] PH_SAMPLE   = 4'(LOW_PHASE_CNT + 1);
  localparam logic [3:0] PH_SDA_EDGE = 4'(LOW_PHASE_CNT + 2);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {M_IDLE, M_TX, M_RX} i2cms_mode_t;
  typedef enum logic [2:0] {
    E_IDLE, E_START, E_ADDR, E_AACK, E_DATA, E_DACK, E_STOP
  } i2cms_eng_t;

  typedef struct packed {
    logic        valid;
    logic        start;
    logic        xfer;
    logic        rx;
    logic        stop;
    logic        ack;
    i2cms_mode_t next;
  } i2cms_op_t;

  typedef struct packed {
    logic busbsy;
    logic idle;
    logic arblst;
    logic datack;
    logic adrack;
    logic error;
    logic busy;
  } i2cms_stat_t;

endpackage

// ==== dv/i2cms_slave_model.sv ====
// two-wire target model for the sequencer bench
// assumes both wires are resolved as open drain with pull-ups
`timescale 1ns/1ps
module i2cms_slave_model #(
  parameter logic [7:0] RD_BYTE = 8'h96
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_pull_o,
  output logic [7:0]      got_o,
  output logic            mack_o,
  output int              starts_o,
  output int              stops_o
);
  int         bitn = 9;
  int         byten = 0;
  logic       rd = 1'b0;
  logic [7:0] sh = 8'h00;
  // counters start clean, sda released
  initial begin
    sda_pull_o = 1'b0;
    starts_o = 0;
    stops_o = 0;
  end
  // start or stop is an sda edge while scl is high
  always @(negedge sda_i) if (scl_i) begin
    starts_o++;
    bitn = -1;
    byten = 0;
    sda_pull_o = 1'b0;
  end
  always @(posedge sda_i) if (scl_i) stops_o++;
  // sample on scl rise; a nack from the master ends our read data
  always @(posedge scl_i) begin
    if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda_i};
    if (bitn == 7 && byten == 1) rd = sda_i;
    if (bitn == 8 && byten > 1 && !rd) got_o = sh;
    if (bitn == 8 && byten > 1 && rd) mack_o = sda_i;
    if (bitn == 8 && byten > 1 && rd && sda_i) rd = 1'b0;
  end
  // slots advance on scl fall; acks address and writes, reads go msb first
  always @(negedge scl_i) begin
    bitn = (bitn == 8) ? 0 : bitn + 1;
    if (bitn == 0) byten++;
    sda_pull_o = (bitn == 8) ? (byten == 1 || !rd)
                             : (rd && byten > 1 && !RD_BYTE[7 - bitn]);
  end
endmodule

// ==== dv/tb.sv ====
// self-checking bench of the two-wire master command sequencer
// assumes the package, the design and the target model compile first
`timescale 1ns/1ps
module tb;
  import i2cms_pkg::*;
  localparam int PER = 2;
  logic        core_clk_i;
  logic        rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, pready_o, pslverr_o, slverr, scl_q;
  logic        scl_oe, sda_oe, sda_pull, raw_int_o, irq_o, mack;
  logic        scl_lvl, sda_lvl;
  logic [7:0]  paddr_i = 8'h00, got;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  int          starts, stops, per_cnt, last_per, err_count, num_checks;
  wire         scl = !scl_oe;
  wire         sda = !sda_oe && !sda_pull;
  // dir, kind (0 send, 1 receive, 2 none, 3 refused), command nibble
  // a stop in receive only follows a master nack
  logic [7:0]  seq [24] = '{8'h03, 8'hBF, 8'h01, 8'h03, 8'h93, 8'h9B,
    8'h99, 8'h3D, 8'h91, 8'h03, 8'h05, 8'h03, 8'h07, 8'h9B, 8'h95, 8'h93,
    8'h97, 8'h03, 8'h97, 8'h03, 8'h24, 8'h93, 8'hA4, 8'h32};
  i2cms_top uut (
    .core_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .scl_i(scl), .scl_o(scl_lvl),
    .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_lvl), .sda_oe_o(sda_oe),
    .raw_int_o, .irq_o);
  i2cms_slave_model peer (.scl_i(scl), .sda_i(sda), .sda_pull_o(sda_pull),
    .got_o(got), .mack_o(mack), .starts_o(starts), .stops_o(stops));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = !core_clk_i;
  end
  // clocks between scl rises, for the serial period
  always @(posedge core_clk_i) begin
    scl_q <= scl;
    per_cnt <= (scl && !scl_q) ? 1 : per_cnt + 1;
    if (scl && !scl_q) last_per <= per_cnt;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, g, x);
    end
  endtask
  // one apb transfer; a read is compared with x
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
    if (!w) chk(prdata_o, x);
    slverr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic t_regs();
    apb(1'b0, OFF_DATA, 32'h0, 32'h0);
    apb(1'b0, OFF_PERIOD, 32'h0, 32'h1);
    apb(1'b0, OFF_IMASK, 32'h0, 32'h0);
    apb(1'b1, OFF_DATA, 32'h0000_00A5, 32'h0);
    apb(1'b0, OFF_DATA, 32'h0, 32'hA5);
    apb(1'b1, OFF_PERIOD, 32'(PER), 32'h0);
    apb(1'b0, OFF_PERIOD, 32'h0, 32'(PER));
    apb(1'b1, OFF_IMASK, 32'h1, 32'h0);
    apb(1'b0, OFF_IMASK, 32'h0, 32'h1);
    apb(1'b0, 8'h20, 32'h0, 32'h0);
    chk(32'(slverr), 32'h1);
    chk(32'({scl_lvl, sda_lvl}), 32'h0);
  endtask
  // one command from the table, judged on the wire and in the registers
  task automatic op(input logic [7:0] e, input int i);
    int s0, p0, n;
    s0 = starts;
    p0 = stops;
    apb(1'b1, OFF_SLV_ADDR, {24'h0, 7'h2A, e[7]}, 32'h0);
    apb(1'b1, OFF_DATA, 32'h40 + 32'(i), 32'h0);
    apb(1'b1, OFF_CMD_STAT, {28'h0, e[3:0]}, 32'h0);
    if (e[5:4] == 2'h3) begin
      repeat (400) @(posedge core_clk_i);
      chk(32'(raw_int_o), 32'h0);
      chk(32'(starts - s0), 32'h0);
      return;
    end
    apb(1'b0, OFF_CMD_STAT, 32'h0, 32'h1);
    for (n = 0; n < 3000 && raw_int_o !== 1'b1; n++) @(posedge core_clk_i);
    if (raw_int_o !== 1'b1) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
    @(posedge core_clk_i);
    chk(32'(irq_o), 32'(i < 11));
    apb(1'b1, OFF_INT_CLR, 32'h1, 32'h0);
    // settled status: idle after a stop, otherwise the bus is still owned
    apb(1'b0, OFF_CMD_STAT, 32'h0, e[2] ? 32'h20 : 32'h40);
    chk(32'(raw_int_o), 32'h0);
    chk(32'(starts - s0), 32'(e[1]));
    chk(32'(stops - p0), 32'(e[2]));
    if (e[5:4] != 2'h2)
      chk(32'(last_per), 32'(2 * (1 + PER) * SLOT_PHASES));
    if (e[5:4] == 2'h0) chk(32'(got), 32'h40 + 32'(i));
    if (e[5:4] != 2'h1) return;
    apb(1'b0, OFF_DATA, 32'h0, 32'h96);
    chk(32'(mack), 32'(!e[3]));
  endtask
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // reset, registers, then the whole command table in order
  initial begin
    repeat (5) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    t_regs();
    foreach (seq[i]) begin
      if (i == 11) apb(1'b1, OFF_IMASK, 32'h0, 32'h0);
      op(seq[i], i);
    end
    finish_test();
  end
endmodule
